// [rtl/dpr_pkg.sv]
// Notes on behaviour
// - enabled port with read select high reads its addressed word onto its output.
// - enabled port with read select low writes its input data at its address.
// - each port depth lies in 1..65536 words and width in 1..576 bits.
// - depth times width is the same seen from both ports.
// - ports may have different aspect ratios holding the same total bits.
// - both ports run on one shared clock; there are no independent port clocks.
// - active clock edge is a build choice, realised by inverting that clock.
// - optional output pipeline stage per port, fixed at build time only.
// - in initialization mode both ports are blocked; only load strobes write, no write-through.
// - active-low freeze input stops port reading and writing; flash load and save are not gated.
// - initialization or save switches the array to 9-bit organisation.
// - four separate 9-bit save-data buses, one per flash input.
// - low-power build uses depth cascading across the four blocks; the high-speed build has no such width limit.
// - low-power build rejects configurations depth cascading cannot realise.
// - unused memory block inputs are tied to ground.
// - reset clears the data and save outputs and the control registers, never the stored contents.
// - during initialization a block's load strobe writes load data at load address.
// - during save the load address location is read onto the save outputs.
package dpr_pkg;
  // user organisation: port A 256 x 16, port B 512 x 8
  localparam int A_DEPTH     = 256;
  localparam int A_WIDTH     = 16;
  localparam int A_AW        = 8;
  localparam int B_DEPTH     = 512;
  localparam int B_WIDTH     = 8;
  localparam int B_AW        = 9;
  // physical organisation: four blocks of 128 nine-bit cells
  localparam int CELL_W      = 9;
  localparam int USER_W      = 8;
  localparam int BLOCKS      = 4;
  localparam int BLOCK_CELLS = 128;
  localparam int ROW_W       = 7;
  localparam int CELL_AW     = 9;
  // build options
  localparam bit LOW_POWER_OPT         = 1'b1;
  localparam int DEPTH_CASCADE_MAX_W   = 18;
  localparam bit SHARED_CLOCK_INVERT   = 1'b0;
  localparam bit PORT_A_OUTPUT_REGISTER = 1'b0;
  localparam bit PORT_B_OUTPUT_REGISTER = 1'b1;
  localparam bit PORT_A_SHOW_WRITE     = 1'b0;
  localparam bit PORT_B_SHOW_WRITE     = 1'b1;
  // elaboration fails through a divide by zero when a build is not realisable
  localparam int MAX_DEPTH = 65536;
  localparam int MAX_WIDTH = 576;
  localparam int RANGE_OK = (A_DEPTH >= 1 && A_DEPTH <= MAX_DEPTH && B_DEPTH >= 1 &&
                             B_DEPTH <= MAX_DEPTH && A_WIDTH >= 1 && A_WIDTH <= MAX_WIDTH &&
                             B_WIDTH >= 1 && B_WIDTH <= MAX_WIDTH) ? 1 : 0;
  localparam int CAP_OK   = (A_DEPTH * A_WIDTH == B_DEPTH * B_WIDTH) ? 1 : 0;
  localparam int LP_OK    = (LOW_POWER_OPT && (A_WIDTH > DEPTH_CASCADE_MAX_W ||
                             B_WIDTH > DEPTH_CASCADE_MAX_W)) ? 0 : 1;
  localparam int BUILD_CHECK = 1 / (CAP_OK * LP_OK * RANGE_OK);
  // register map
  localparam int         AXI_AW       = 8;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_WRCOUNT  = 8'h08;
  localparam int         CTRL_LOAD    = 0;
  localparam int         CTRL_SAVE    = 1;
  localparam int         ST_FROZEN    = 0;
  localparam int         ST_LOWPWR    = 1;
  localparam int         ST_INIT      = 2;
  localparam logic [1:0] CTRL_RESET   = 2'h0;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam int         WRCOUNT_W    = 16;
endpackage

// [rtl/dpr_top.sv]
`timescale 1ns/1ps
module dpr_top (
  // clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           reset_n,
  // port A
  input  wire logic                           port_a_select,
  input  wire logic                           port_a_read_not_write,
  input  wire logic [dpr_pkg::A_AW-1:0]       port_a_address,
  input  wire logic [dpr_pkg::A_WIDTH-1:0]    port_a_write_data,
  output logic      [dpr_pkg::A_WIDTH-1:0]    port_a_read_data,
  // port B
  input  wire logic                           port_b_select,
  input  wire logic                           port_b_read_not_write,
  input  wire logic [dpr_pkg::B_AW-1:0]       port_b_address,
  input  wire logic [dpr_pkg::B_WIDTH-1:0]    port_b_write_data,
  output logic      [dpr_pkg::B_WIDTH-1:0]    port_b_read_data,
  // power pins, asynchronous
  input  wire logic                           low_power_request,
  input  wire logic                           freeze_request_n,
  // flash load and save interface
  input  wire logic [dpr_pkg::ROW_W-1:0]      load_address,
  input  wire logic [dpr_pkg::CELL_W-1:0]     load_data,
  input  wire logic [dpr_pkg::BLOCKS-1:0]     load_strobe,
  output logic      [dpr_pkg::CELL_W-1:0]     save_data_out_0,
  output logic      [dpr_pkg::CELL_W-1:0]     save_data_out_1,
  output logic      [dpr_pkg::CELL_W-1:0]     save_data_out_2,
  output logic      [dpr_pkg::CELL_W-1:0]     save_data_out_3,
  // axi4-lite slave
  input  wire logic [dpr_pkg::AXI_AW-1:0]     s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic      [1:0]                     s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [dpr_pkg::AXI_AW-1:0]     s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic      [31:0]                    s_axi_rdata,
  output logic      [1:0]                     s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready
);

  function automatic logic [1:0] cell_blk(input logic [dpr_pkg::CELL_AW-1:0] c);
    cell_blk = c[dpr_pkg::CELL_AW-1:dpr_pkg::ROW_W];
  endfunction

  function automatic logic [dpr_pkg::ROW_W-1:0] cell_row(
    input logic [dpr_pkg::CELL_AW-1:0] c);
    cell_row = c[dpr_pkg::ROW_W-1:0];
  endfunction

  // word index of a byte address; the two low bits never select a register
  function automatic logic [dpr_pkg::AXI_AW-3:0] reg_index(
    input logic [dpr_pkg::AXI_AW-1:0] a);
    reg_index = a[dpr_pkg::AXI_AW-1:2];
  endfunction

  // 9-bit cells; user words use the low eight bits of each cell
  logic [dpr_pkg::CELL_W-1:0] mem [dpr_pkg::BLOCKS][dpr_pkg::BLOCK_CELLS];

  logic                          lp_s1_r;
  logic                          lp_s2_r;
  logic                          fz_s1_r;
  logic                          fz_s2_r;
  logic [1:0]                    ctrl_r;
  logic [dpr_pkg::WRCOUNT_W-1:0] wr_count_r;
  logic [dpr_pkg::A_WIDTH-1:0]   a_q_r;
  logic [dpr_pkg::B_WIDTH-1:0]   b_q_r;
  logic [dpr_pkg::CELL_W-1:0]    sv_r [dpr_pkg::BLOCKS];
  logic                          aw_hold_r;
  logic                          w_hold_r;
  logic [dpr_pkg::AXI_AW-1:0]    awaddr_r;
  logic [31:0]                   wdata_r;
  logic                          wstrb0_r;

  wire logic shared_clock;
  wire logic load_mode_active;
  wire logic save_mode_active;
  wire logic init_mode;
  wire logic quiet;
  wire logic a_go;
  wire logic a_wr;
  wire logic a_rd;
  wire logic b_go;
  wire logic b_wr;
  wire logic b_rd;
  wire logic [dpr_pkg::CELL_AW-1:0] a_lo_cell;
  wire logic [dpr_pkg::CELL_AW-1:0] a_hi_cell;
  wire logic [dpr_pkg::CELL_AW-1:0] b_cell;
  wire logic [dpr_pkg::A_WIDTH-1:0] a_mem_word;
  wire logic [dpr_pkg::B_WIDTH-1:0] b_mem_word;
  wire logic                        frozen;
  wire logic                        wr_fire;
  wire logic                        wr_sel_ctrl;
  wire logic                        wr_ctrl;
  wire logic                        rd_sel_ctrl;
  wire logic                        rd_sel_status;
  wire logic                        rd_sel_count;
  wire logic                        rd_hit;
  wire logic [31:0]                 ctrl_word;
  wire logic [31:0]                 status_word;
  wire logic [31:0]                 count_word;
  wire logic [31:0]                 rd_word;

  assign shared_clock = sys_clk ^ dpr_pkg::SHARED_CLOCK_INVERT;

  assign load_mode_active = ctrl_r[dpr_pkg::CTRL_LOAD];
  assign save_mode_active = ctrl_r[dpr_pkg::CTRL_SAVE];
  assign init_mode        = load_mode_active | save_mode_active;

  // freeze blocks access
  // deselect also under low power, so a late request cannot corrupt a cell
  assign frozen = ~fz_s2_r;
  assign quiet  = lp_s2_r | frozen;

  assign a_go = port_a_select & ~init_mode & ~quiet;
  assign a_wr = a_go & ~port_a_read_not_write;
  assign a_rd = a_go & port_a_read_not_write;
  assign b_go = port_b_select & ~init_mode & ~quiet;
  assign b_wr = b_go & ~port_b_read_not_write;
  assign b_rd = b_go & port_b_read_not_write;

  // mixed aspect ratios
  // low byte of a port A word sits in the lower cell address
  assign a_lo_cell = {port_a_address, 1'b0};
  assign a_hi_cell = {port_a_address, 1'b1};
  assign b_cell    = port_b_address;

  assign a_mem_word = {mem[cell_blk(a_hi_cell)][cell_row(a_hi_cell)][dpr_pkg::USER_W-1:0],
                       mem[cell_blk(a_lo_cell)][cell_row(a_lo_cell)][dpr_pkg::USER_W-1:0]};
  assign b_mem_word = mem[cell_blk(b_cell)][cell_row(b_cell)][dpr_pkg::USER_W-1:0];

  always_ff @(posedge sys_clk) begin
    lp_s1_r <= low_power_request;
    lp_s2_r <= lp_s1_r;
    fz_s1_r <= freeze_request_n;
    fz_s2_r <= fz_s1_r;
  end

  // memory has no reset on purpose
  always_ff @(posedge shared_clock) begin
    for (int k = 0; k < dpr_pkg::BLOCKS; k++) begin
      if (load_mode_active && load_strobe[k]) begin
        mem[k][load_address] <= load_data;
      end
    end
    if (a_wr) begin
      mem[cell_blk(a_lo_cell)][cell_row(a_lo_cell)] <= {1'b0, port_a_write_data[7:0]};
      mem[cell_blk(a_hi_cell)][cell_row(a_hi_cell)] <= {1'b0, port_a_write_data[15:8]};
    end
    if (b_wr) begin
      mem[cell_blk(b_cell)][cell_row(b_cell)] <= {1'b0, port_b_write_data};
    end
  end

  always_ff @(posedge shared_clock) begin
    if (!reset_n) begin
      a_q_r <= '0;
      b_q_r <= '0;
    end else begin
      if (a_rd) begin
        a_q_r <= a_mem_word;
      end else if (a_wr && dpr_pkg::PORT_A_SHOW_WRITE) begin
        a_q_r <= port_a_write_data;
      end
      if (b_rd) begin
        b_q_r <= b_mem_word;
      end else if (b_wr && dpr_pkg::PORT_B_SHOW_WRITE) begin
        b_q_r <= port_b_write_data;
      end
    end
  end

  always_ff @(posedge shared_clock) begin
    for (int k = 0; k < dpr_pkg::BLOCKS; k++) begin
      if (!reset_n) begin
        sv_r[k] <= '0;
      end else if (save_mode_active) begin
        sv_r[k] <= mem[k][load_address];
      end
    end
  end

  assign save_data_out_0 = sv_r[0];
  assign save_data_out_1 = sv_r[1];
  assign save_data_out_2 = sv_r[2];
  assign save_data_out_3 = sv_r[3];

  generate
    if (dpr_pkg::PORT_A_OUTPUT_REGISTER) begin : g_pipe_a
      logic [dpr_pkg::A_WIDTH-1:0] a_p_r;
      always_ff @(posedge shared_clock) begin
        if (!reset_n) begin
          a_p_r <= '0;
        end else begin
          a_p_r <= a_q_r;
        end
      end
      assign port_a_read_data = a_p_r;
    end else begin : g_flow_a
      assign port_a_read_data = a_q_r;
    end
    if (dpr_pkg::PORT_B_OUTPUT_REGISTER) begin : g_pipe_b
      logic [dpr_pkg::B_WIDTH-1:0] b_p_r;
      always_ff @(posedge shared_clock) begin
        if (!reset_n) begin
          b_p_r <= '0;
        end else begin
          b_p_r <= b_q_r;
        end
      end
      assign port_b_read_data = b_p_r;
    end else begin : g_flow_b
      assign port_b_read_data = b_q_r;
    end
  endgenerate

  // register slave
  assign wr_fire       = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  assign wr_sel_ctrl   = reg_index(awaddr_r) == reg_index(dpr_pkg::REG_CTRL);
  // a control write without its low byte lane leaves the modes alone
  assign wr_ctrl       = wr_fire & wr_sel_ctrl & wstrb0_r;
  assign rd_sel_ctrl   = reg_index(s_axi_araddr) == reg_index(dpr_pkg::REG_CTRL);
  assign rd_sel_status = reg_index(s_axi_araddr) == reg_index(dpr_pkg::REG_STATUS);
  assign rd_sel_count  = reg_index(s_axi_araddr) == reg_index(dpr_pkg::REG_WRCOUNT);
  assign rd_hit        = rd_sel_ctrl | rd_sel_status | rd_sel_count;
  assign ctrl_word     = {30'h0, ctrl_r};
  assign count_word    = {16'h0, wr_count_r};
  assign status_word   = (32'(init_mode) << dpr_pkg::ST_INIT) |
                         (32'(lp_s2_r) << dpr_pkg::ST_LOWPWR) |
                         (32'(frozen) << dpr_pkg::ST_FROZEN);
  assign rd_word       = rd_sel_ctrl   ? ctrl_word   :
                         rd_sel_status ? status_word :
                         rd_sel_count  ? count_word  : 32'h0;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_r     <= dpr_pkg::CTRL_RESET;
      wr_count_r <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_r[1:0];
      end
      wr_count_r <= wr_count_r + dpr_pkg::WRCOUNT_W'(a_wr | b_wr);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= dpr_pkg::RESP_OKAY;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb0_r      <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_hold_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_hold_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb0_r     <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_sel_ctrl ? dpr_pkg::RESP_OKAY : dpr_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= dpr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? dpr_pkg::RESP_OKAY : dpr_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// [sim/dpr_props.sv]
`timescale 1ns/1ps
module dpr_props (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // memory ports
  input wire logic        port_a_select,
  input wire logic        port_a_read_not_write,
  input wire logic [7:0]  port_a_address,
  input wire logic [15:0] port_a_write_data,
  input wire logic [15:0] port_a_read_data,
  input wire logic        port_b_select,
  input wire logic        port_b_read_not_write,
  input wire logic [8:0]  port_b_address,
  input wire logic [7:0]  port_b_write_data,
  input wire logic [7:0]  port_b_read_data,
  // power and save
  input wire logic        low_power_request,
  input wire logic        freeze_request_n,
  input wire logic [8:0]  save_data_out_0,
  // register bus write side
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  logic [1:0] mode_r;
  logic [7:0] aw_r;
  logic [1:0] wd_r;
  logic       ws_r;
  logic [2:0] lp_r;
  logic [2:0] ff_r;
  // pins are judged over three samples, wider than the design's synchroniser
  always_ff @(posedge sys_clk) begin
    lp_r <= {lp_r[1:0], low_power_request};
    ff_r <= {ff_r[1:0], freeze_request_n};
    if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) begin
      wd_r <= s_axi_wdata[1:0];
      ws_r <= s_axi_wstrb[0];
    end
    // a control write without the low byte lane leaves the modes alone
    if (!reset_n) mode_r <= 2'h0;
    else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == dpr_pkg::RESP_OKAY &&
             aw_r == dpr_pkg::REG_CTRL && ws_r) mode_r <= wd_r;
  end
  wire ok = mode_r == 2'h0 && !s_axi_bvalid && lp_r == 3'h0 && ff_r == 3'h7 &&
            !low_power_request && freeze_request_n;
  wire a_any = port_a_select && !port_a_read_not_write;
  wire b_any = port_b_select && !port_b_read_not_write;
  wire a_wr = ok && a_any;
  wire a_rd = ok && port_a_select && port_a_read_not_write;
  wire b_wr = ok && b_any;
  wire b_rd = ok && port_b_select && port_b_read_not_write;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  AST_RESET_CLEAR: assert property (
    $rose(reset_n) |-> port_a_read_data == 16'h0 && port_b_read_data == 8'h0 &&
    save_data_out_0 == 9'h0) else $error("outputs not cleared by reset");
  AST_A_WR_RD: assert property (
    a_wr && !b_any ##1 a_rd && !b_any && $stable(port_a_address) |=>
    port_a_read_data == $past(port_a_write_data, 2)) else $error("port a readback wrong");
  AST_B_WR_RD: assert property (
    b_wr ##1 b_rd && !a_any && $stable(port_b_address) |-> ##2
    port_b_read_data == $past(port_b_write_data, 3)) else $error("port b readback wrong");
  AST_A_WR_HOLD: assert property (
    a_wr |=> $stable(port_a_read_data)) else $error("port a output moved on write");
  AST_B_SHOW_WR: assert property (
    b_wr |-> ##2 port_b_read_data == $past(port_b_write_data, 2))
    else $error("port b does not show written byte");
  AST_A_IDLE_HOLD: assert property (
    !port_a_select |=> $stable(port_a_read_data)) else $error("idle port a output moved");
  AST_B_IDLE_HOLD: assert property (
    !port_b_select |-> ##2 $stable(port_b_read_data)) else $error("idle port b output moved");
  AST_FREEZE_BLOCK: assert property (
    !freeze_request_n [*3] ##0 port_a_select |=> $stable(port_a_read_data))
    else $error("port a active while frozen");
  AST_SAVE_HOLD: assert property (
    mode_r[dpr_pkg::CTRL_SAVE] == 1'h0 && !s_axi_bvalid |=> $stable(save_data_out_0))
    else $error("save output moved outside save mode");
  cover property (a_wr ##1 a_rd);
  cover property (b_wr ##1 b_rd);
  cover property (!freeze_request_n [*3] ##0 port_a_select);
endmodule
bind dpr_top dpr_props u_dpr_props (.*);

// [sim/dpr_user.sv]
`timescale 1ns/1ps
module dpr_user (
  // clock
  input wire logic sys_clk,
  // port a
  output logic        port_a_select,
  output logic        port_a_read_not_write,
  output logic [7:0]  port_a_address,
  output logic [15:0] port_a_write_data,
  // port b
  output logic        port_b_select,
  output logic        port_b_read_not_write,
  output logic [8:0]  port_b_address,
  output logic [7:0]  port_b_write_data,
  // power pins
  output logic        low_power_request,
  output logic        freeze_request_n
);
  initial begin
    {port_a_select, port_b_select, low_power_request} = 3'h0;
    {port_a_read_not_write, port_b_read_not_write, freeze_request_n} = 3'h7;
    {port_a_address, port_b_address, port_a_write_data, port_b_write_data} = 41'h0;
  end
  task automatic op(input bit p, input bit rd, input logic [8:0] ad, input logic [15:0] d);
    port_a_select <= !p;
    port_b_select <= p;
    port_a_read_not_write <= rd;
    port_b_read_not_write <= rd;
    port_a_address <= ad[8:1];
    port_b_address <= ad;
    port_a_write_data <= p ? ~port_a_write_data : d;
    port_b_write_data <= p ? d[7:0] : ~port_b_write_data;
    @(posedge sys_clk);
  endtask
  // idle data lines keep moving so stale values are never trusted
  task automatic idle();
    port_a_select <= 1'h0;
    port_b_select <= 1'h0;
    port_a_write_data <= ~port_a_write_data;
    port_b_write_data <= ~port_b_write_data;
  endtask
  task automatic pins(input logic lp, input logic ff_n);
    low_power_request <= lp;
    freeze_request_n <= ff_n;
  endtask
endmodule

// [sim/tb_dpr_top.sv]
`timescale 1ns/1ps
module tb_dpr_top;
  logic        sys_clk, reset_n, port_a_select, port_a_read_not_write;
  logic        port_b_select, port_b_read_not_write, low_power_request, freeze_request_n;
  logic [7:0]  port_a_address, port_b_write_data, port_b_read_data, s_axi_awaddr, s_axi_araddr;
  logic [8:0]  port_b_address, load_data, save_data_out_0, save_data_out_1, save_data_out_2;
  logic [8:0]  save_data_out_3;
  logic [15:0] port_a_write_data, port_a_read_data;
  logic [6:0]  load_address;
  logic [3:0]  load_strobe, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, x, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  mem [512];
  int          miscompares, checks, i;
  dpr_top u_dpr_top (.*);
  dpr_user u_dpr_user (.*);
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  function automatic logic [15:0] word(input logic [8:0] ad);
    return {mem[{ad[8:1], 1'h1}], mem[{ad[8:1], 1'h0}]};
  endfunction
  function automatic logic [8:0] ld(input int k);
    return 9'h155 ^ 9'(k * 37);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] v,
                     input logic [3:0] s);
    int n;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, v, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    {d, rs} = wr ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
    if (n == 40) begin
      miscompares++;
      complete_run();
    end else begin
      @(posedge sys_clk);
    end
  endtask
  task automatic rd_both(input bit p, input logic [8:0] ad);
    u_dpr_user.op(p, 1'h1, ad, 16'h0);
    u_dpr_user.op(!p, 1'h1, ad, 16'h0);
    u_dpr_user.idle();
    repeat (2) @(posedge sys_clk);
    chk("a_rd", {16'h0, word(ad)}, {16'h0, port_a_read_data});
    chk("b_rd", {24'h0, mem[ad]}, {24'h0, port_b_read_data});
  endtask
  task automatic wr_rd(input bit p, input logic [8:0] ad, input logic [15:0] v);
    u_dpr_user.op(p, 1'h0, ad, v);
    if (p) mem[ad] = v[7:0];
    else {mem[{ad[8:1], 1'h1}], mem[{ad[8:1], 1'h0}]} = v;
    rd_both(p, ad);
  endtask
  task automatic rst();
    reset_n <= 1'h0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'h1;
    @(posedge sys_clk);
    chk("a_clr", 32'h0, {16'h0, port_a_read_data});
    chk("b_clr", 32'h0, {24'h0, port_b_read_data});
  endtask
  task automatic chk_save();
    chk("sv0", {23'h0, ld(0)}, {23'h0, save_data_out_0});
    chk("sv1", {23'h0, ld(1)}, {23'h0, save_data_out_1});
    chk("sv2", {23'h0, ld(2)}, {23'h0, save_data_out_2});
    chk("sv3", {23'h0, ld(3)}, {23'h0, save_data_out_3});
  endtask
  initial begin
    x = 32'h28;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {load_address, load_data, load_strobe} = 20'h0;
    rst();
    axi(1'h0, dpr_pkg::REG_CTRL, 32'h0, 4'h0);
    chk("ctrl", 32'h0, d);
    for (i = 0; i < 512; i += 2) begin
      d = rnd();
      wr_rd(1'h0, 9'(i), d[15:0]);
    end
    wr_rd(1'h1, 9'h1ff, 16'h00a5);
    for (i = 0; i < 60; i++) begin
      d = rnd();
      wr_rd(d[0], d[9:1], d[31:16]);
    end
    rst();
    rd_both(1'h1, 9'h1ff);
    u_dpr_user.pins(1'h0, 1'h0);
    repeat (3) @(posedge sys_clk);
    axi(1'h0, dpr_pkg::REG_STATUS, 32'h0, 4'h0);
    chk("status_ff", 32'h1 << dpr_pkg::ST_FROZEN, d);
    u_dpr_user.op(1'h0, 1'h0, 9'h004, 16'h1234);
    u_dpr_user.idle();
    u_dpr_user.pins(1'h0, 1'h1);
    repeat (3) @(posedge sys_clk);
    rd_both(1'h0, 9'h004);
    axi(1'h0, dpr_pkg::REG_WRCOUNT, 32'h0, 4'h0);
    chk("wrcount", 32'h0, d);
    u_dpr_user.pins(1'h1, 1'h1);
    repeat (3) @(posedge sys_clk);
    axi(1'h0, dpr_pkg::REG_STATUS, 32'h0, 4'h0);
    chk("status_lp", 32'h1 << dpr_pkg::ST_LOWPWR, d);
    u_dpr_user.pins(1'h0, 1'h1);
    repeat (3) @(posedge sys_clk);
    wr_rd(1'h0, 9'h0c8, 16'h5a3c);
    axi(1'h0, dpr_pkg::REG_WRCOUNT, 32'h0, 4'h0);
    chk("wrcount", 32'h1, d);
    axi(1'h0, 8'hfc, 32'h0, 4'h0);
    chk("unmapped", {30'h0, dpr_pkg::RESP_SLVERR}, {d[29:0], rs});
    axi(1'h1, dpr_pkg::REG_STATUS, 32'h7, 4'hf);
    chk("ro_write", {30'h0, dpr_pkg::RESP_SLVERR}, {30'h0, rs});
    axi(1'h1, dpr_pkg::REG_CTRL, 32'h1, 4'h0);
    axi(1'h0, dpr_pkg::REG_CTRL, 32'h0, 4'h0);
    chk("ctrl_strb", 32'h0, d);
    axi(1'h1, dpr_pkg::REG_CTRL, 32'h1 << dpr_pkg::CTRL_LOAD, 4'h1);
    axi(1'h0, dpr_pkg::REG_STATUS, 32'h0, 4'h0);
    chk("status_init", 32'h1 << dpr_pkg::ST_INIT, d);
    u_dpr_user.op(1'h0, 1'h0, 9'h004, 16'hbeef);
    u_dpr_user.idle();
    load_address <= 7'h2a;
    for (i = 0; i < 4; i++) begin
      load_strobe <= 4'h1 << i;
      load_data <= ld(i);
      @(posedge sys_clk);
    end
    load_strobe <= 4'h0;
    axi(1'h1, dpr_pkg::REG_CTRL, 32'h1 << dpr_pkg::CTRL_SAVE, 4'h1);
    repeat (2) @(posedge sys_clk);
    chk_save();
    axi(1'h1, dpr_pkg::REG_CTRL, 32'h0, 4'h1);
    load_strobe <= 4'hf;
    load_data <= 9'h0;
    @(posedge sys_clk);
    load_strobe <= 4'h0;
    axi(1'h1, dpr_pkg::REG_CTRL, 32'h1 << dpr_pkg::CTRL_SAVE, 4'h1);
    repeat (2) @(posedge sys_clk);
    chk_save();
    axi(1'h1, dpr_pkg::REG_CTRL, 32'h0, 4'h1);
    rd_both(1'h0, 9'h004);
    complete_run();
  end
endmodule
